// *** tb/ext_test_system.sv ***
/*
  External test system that drives the switch, trigger and shutdown pins.
  Assumes the bench calls its tasks and a free-running clock at the design's rate.
*/
`timescale 1ns/1ns
`default_nettype none

module ext_test_system (
  input wire logic clk,
  output logic switch_pin,
  output logic trig_pin,
  output logic shdn_pin
);
  // ************************************************************
  // Idle levels
  // ************************************************************
  initial begin
    switch_pin = 1'b1;
    trig_pin = 1'b1;
    shdn_pin = 1'b0;
  end

  // ************************************************************
  // Pin drivers
  // ************************************************************
  // Level held until the next call
  task automatic set_switch(input logic v);
    @(posedge clk);
    switch_pin <= v;
  endtask

  // Low for n cycles, then high long enough to rearm
  task automatic pull_trigger(input int n);
    @(posedge clk);
    trig_pin <= 1'b0;
    repeat (n) @(posedge clk);
    trig_pin <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  task automatic set_shutdown(input logic v);
    @(posedge clk);
    shdn_pin <= v;
  endtask
endmodule // ext_test_system

`default_nettype wire

// *** tb/tb_top.sv ***
/*
  Self-checking bench: register tasks over the AXI4-Lite bus, pin stimulus by the partner model.
  Assumes the design top, its map header and the partner model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "octl_map.svh"

module tb_top;
  localparam int QUAL = `QUAL_CYCLES;
  localparam int LONG = `QUAL_CYCLES + 200;
  localparam int O_EN = 5;
  localparam int O_RED = 4;
  localparam int O_OFF = 2;
  localparam int O_IRQ = 0;
  logic core_clk, rst_n, ce;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, strb;
  logic [1:0] bresp, rresp;
  logic out_en, fault_red, power_ok, off_flag, trig_event, irq;
  wire logic sw_pin, trig_pin, shdn_pin;
  logic [5:0] outs;
  int miscompares, check_count, cycles, trig_count, off_hi, off_lo, n;

  assign outs = {out_en, fault_red, power_ok, off_flag, trig_event, irq};

  // ************************************************************
  // Instances
  // ************************************************************
  output_control_trigger_inputs output_control_trigger_inputs_i (
    .CORE_CLK(core_clk), .RST_N(rst_n), .CE(ce), .REMOTE_SWITCH_IN(sw_pin),
    .EXTERNAL_TRIGGER_IN(trig_pin), .ISOLATED_SHUTDOWN_IN(shdn_pin), .OUTPUT_ENABLE(out_en),
    .POWER_FAULT_RED(fault_red), .POWER_OK_FLAG_ON(power_ok), .OUTPUT_OFF_FLAG_ON(off_flag),
    .TRIGGER_EVENT(trig_event), .IRQ(irq), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready),
    .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp)
  );
  ext_test_system ext_test_system_i (
    .clk(core_clk), .switch_pin(sw_pin), .trig_pin(trig_pin), .shdn_pin(shdn_pin)
  );

  // ************************************************************
  // Clock, counters, timeout
  // ************************************************************
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (trig_event === 1'b1) trig_count <= trig_count + 1;
    if (off_flag === 1'b1) off_hi <= off_hi + 1;
    if (off_flag === 1'b0) off_lo <= off_lo + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_out(input int i, input logic v, input int lim, input string name);
    int k;
    k = 0;
    while (outs[i] !== v && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    check(name, {31'h0, v}, {31'h0, outs[i]});
  endtask

  task automatic hold_out(input int i, input logic v, input int len, input string name);
    logic ok;
    ok = 1'b1;
    repeat (len) begin
      @(posedge core_clk);
      if (outs[i] !== v) ok = 1'b0;
    end
    check(name, 32'h1, {31'h0, ok});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic got;
    logic [1:0] r;
    @(posedge core_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= strb;
    bready <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        got = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    check("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    logic got;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(posedge core_clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        got = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    check("rdata", e, d & m);
    check("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {rst_n, ce, awvalid, wvalid, bready, arvalid, rready} = 7'b0100000;
    {awaddr, araddr, wdata, wstrb} = '0;
    strb = 4'hf;
    do_reset();
    wait_out(O_EN, 1'b1, 20, "en");
    check("pok", 32'h1, {31'h0, power_ok});
    check("off", 32'h0, {31'h0, off_flag});
    rd(`OFS_CTRL, 32'hffffffff, 32'h0, `AXI_OKAY);
    rd(`OFS_TRIG_CFG, 32'hffffffff, 32'h00010001, `AXI_OKAY);
    rd(`OFS_STATUS, 32'h3f, 32'h29, `AXI_OKAY);
    rd(`OFS_IRQ_MASK, 32'hffffffff, 32'h0, `AXI_OKAY);
    rd(`OFS_CMD, 32'hffffffff, 32'h0, `AXI_OKAY);
    rd(8'h40, 32'hffffffff, 32'h0, `AXI_SLVERR);
    wr(8'h40, 32'h1, `AXI_SLVERR);
    // Unstrobed byte lane leaves the control bits alone
    strb = 4'he;
    wr(`OFS_CTRL, 32'h7, `AXI_OKAY);
    strb = 4'hf;
    rd(`OFS_CTRL, 32'hffffffff, 32'h0, `AXI_OKAY);
    // Default polarity, short low rejected
    ext_test_system_i.set_switch(1'b0);
    hold_out(O_EN, 1'b1, QUAL - 100, "en");
    ext_test_system_i.set_switch(1'b1);
    ext_test_system_i.set_switch(1'b0);
    wait_out(O_EN, 1'b0, LONG, "en");
    check("off", 32'h1, {31'h0, off_flag});
    ext_test_system_i.set_switch(1'b1);
    wait_out(O_EN, 1'b1, 20, "en");
    rd(`OFS_IRQ_STAT, 32'h8, 32'h8, `AXI_OKAY);
    // Inverted sense
    wr(`OFS_CTRL, 32'h1, `AXI_OKAY);
    wait_out(O_EN, 1'b0, LONG, "en");
    ext_test_system_i.set_switch(1'b0);
    wait_out(O_EN, 1'b1, LONG, "en");
    ext_test_system_i.set_switch(1'b1);
    wr(`OFS_CTRL, 32'h0, `AXI_OKAY);
    wait_out(O_EN, 1'b1, LONG, "en");
    // Switch ignored, commands rule
    wr(`OFS_CTRL, 32'h2, `AXI_OKAY);
    ext_test_system_i.set_switch(1'b0);
    hold_out(O_EN, 1'b1, LONG, "en");
    wr(`OFS_CMD, 32'h2, `AXI_OKAY);
    wait_out(O_EN, 1'b0, 10, "en");
    wr(`OFS_CMD, 32'h1, `AXI_OKAY);
    wait_out(O_EN, 1'b1, 10, "en");
    // Standby
    wr(`OFS_CTRL, 32'h4, `AXI_OKAY);
    wait_out(O_EN, 1'b0, LONG, "en");
    rd(`OFS_STATUS, 32'h2, 32'h2, `AXI_OKAY);
    rd(`OFS_IRQ_STAT, 32'h4, 32'h4, `AXI_OKAY);
    ext_test_system_i.set_switch(1'b1);
    hold_out(O_EN, 1'b0, 200, "en");
    wr(`OFS_CMD, 32'h1, `AXI_OKAY);
    wait_out(O_EN, 1'b1, 10, "en");
    wr(`OFS_CTRL, 32'h0, `AXI_OKAY);
    // Trigger input: one event per qualified low, rearm on high
    wr(`OFS_IRQ_STAT, 32'hf, `AXI_OKAY);
    n = trig_count;
    ext_test_system_i.pull_trigger(QUAL + 1000);
    check("trig", n + 1, trig_count);
    ext_test_system_i.pull_trigger(QUAL - 200);
    check("trig", n + 1, trig_count);
    ext_test_system_i.pull_trigger(LONG);
    check("trig", n + 2, trig_count);
    // Clock enable low freezes qualifier and outputs
    @(posedge core_clk);
    ce <= 1'b0;
    n = trig_count;
    ext_test_system_i.pull_trigger(LONG);
    check("trig", n, trig_count);
    check("en", 32'h1, {31'h0, out_en});
    @(posedge core_clk);
    ce <= 1'b1;
    // Interrupt raise, mask, clear
    wr(`OFS_IRQ_MASK, 32'h1, `AXI_OKAY);
    wait_out(O_IRQ, 1'b1, 5, "irq");
    wr(`OFS_IRQ_MASK, 32'h0, `AXI_OKAY);
    wait_out(O_IRQ, 1'b0, 5, "irq");
    wr(`OFS_IRQ_MASK, 32'h1, `AXI_OKAY);
    wr(`OFS_IRQ_STAT, 32'h1, `AXI_OKAY);
    wait_out(O_IRQ, 1'b0, 5, "irq");
    rd(`OFS_IRQ_STAT, 32'h1, 32'h0, `AXI_OKAY);
    // Output-off flag as trigger output
    wr(`OFS_TRIG_CFG, 32'h00040001, `AXI_OKAY);
    wr(`OFS_CMD, 32'h4, `AXI_OKAY);
    rd(`OFS_STATUS, 32'h10, 32'h10, `AXI_OKAY);
    n = off_hi;
    wr(`OFS_CMD, 32'h10, `AXI_OKAY);
    repeat (30) @(posedge core_clk);
    check("pulse", n + 4, off_hi);
    wr(`OFS_TRIG_CFG, 32'h00030000, `AXI_OKAY);
    wr(`OFS_CMD, 32'h4, `AXI_OKAY);
    repeat (2) @(posedge core_clk);
    n = off_lo;
    wr(`OFS_CMD, 32'h10, `AXI_OKAY);
    repeat (30) @(posedge core_clk);
    check("pulse", n + 3, off_lo);
    wr(`OFS_CMD, 32'h8, `AXI_OKAY);
    wait_out(O_OFF, 1'b0, 10, "off");
    // Latched shutdown
    ext_test_system_i.set_shutdown(1'b1);
    wait_out(O_EN, 1'b0, `SHDN_RESP_CYCLES, "en");
    wait_out(O_RED, 1'b1, 5, "red");
    check("pok", 32'h0, {31'h0, power_ok});
    ext_test_system_i.set_shutdown(1'b0);
    hold_out(O_EN, 1'b0, 100, "en");
    wr(`OFS_CMD, 32'h1, `AXI_OKAY);
    hold_out(O_EN, 1'b0, 20, "en");
    do_reset();
    wait_out(O_EN, 1'b1, 20, "en");
    check("red", 32'h0, {31'h0, fault_red});
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire

// *** verilog/octl_map.svh ***
/*
  Constants for the output control and trigger input block: timing, offsets, fields, resets.
  Assumes a 20 MHz core clock; included by its bare name.
*/
`ifndef OCTL_MAP_SVH
`define OCTL_MAP_SVH

// ************************************************************
// Timing
// ************************************************************
`define CLK_MHZ 20
`define QUAL_MIN_US 100
`define QUAL_CYCLES (`QUAL_MIN_US * `CLK_MHZ)
`define QCNT_W 12
`define TRIG_RESP_MAX_US 500
`define TRIG_RESP_CYCLES (`TRIG_RESP_MAX_US * `CLK_MHZ)
`define SHDN_RESP_MAX_US 100
`define SHDN_RESP_CYCLES (`SHDN_RESP_MAX_US * `CLK_MHZ)
`define SWITCH_RESP_MAX_MS 200

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_CTRL 8'h00
`define OFS_TRIG_CFG 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10
`define OFS_CMD 8'h14

// ************************************************************
// Fields
// ************************************************************
`define CMD_OUT_ENABLE 0
`define CMD_OUT_DISABLE 1
`define CMD_LIST_TRIG_SETUP 2
`define CMD_LIST_CLEAR 3
`define CMD_FIRE_TRIG_OUT 4
`define TRIG_WIDTH_LSB 16

// ************************************************************
// Reset values and AXI response codes
// ************************************************************
`define CTRL_RESET 3'h0
`define TRIG_CFG_RESET 17'h00003
`define IRQ_RESET 4'h0
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// *** verilog/octl_pkg.sv ***
/*
  Types for the output control and trigger input block.
  Assumes octl_map.svh for the numbers.
*/
package octl_pkg;

  typedef struct packed {
    logic standby_mode;
    logic ignore_switch;
    logic invert_switch;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] width;
    logic active_level;
  } trig_cfg_t;

  typedef struct packed {
    logic switch_off;
    logic standby;
    logic shutdown;
    logic trigger;
  } irq_t;

  typedef enum logic [1:0] {
    OUT_OFF,
    OUT_ON,
    OUT_STBY,
    OUT_SHDN
  } out_state_t;

endpackage

// *** verilog/output_control_trigger_inputs.sv ***
/*
  Output control and trigger input conditioning with an AXI4-Lite register slave.
  Assumes asynchronous pins on the switch, trigger and shutdown inputs, one 20 MHz clock.
*/
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "octl_map.svh"

module output_control_trigger_inputs (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic REMOTE_SWITCH_IN,
  input wire logic EXTERNAL_TRIGGER_IN,
  input wire logic ISOLATED_SHUTDOWN_IN,
  output logic OUTPUT_ENABLE,
  output logic POWER_FAULT_RED,
  output logic POWER_OK_FLAG_ON,
  output logic OUTPUT_OFF_FLAG_ON,
  output logic TRIGGER_EVENT,
  output logic IRQ,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP
);
  import octl_pkg::*;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `OFS_CTRL, `OFS_TRIG_CFG, `OFS_STATUS, `OFS_IRQ_STAT, `OFS_IRQ_MASK, `OFS_CMD: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    merge = r;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic sw_s1, sw_s2, trg_s1, trg_s2, shd_s1, shd_s2;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sw_s1 <= 1'b1;
      sw_s2 <= 1'b1;
      trg_s1 <= 1'b1;
      trg_s2 <= 1'b1;
      shd_s1 <= 1'b0;
      shd_s2 <= 1'b0;
    end else if (CE) begin
      sw_s1 <= REMOTE_SWITCH_IN;
      sw_s2 <= sw_s1;
      trg_s1 <= EXTERNAL_TRIGGER_IN;
      trg_s2 <= trg_s1;
      shd_s1 <= ISOLATED_SHUTDOWN_IN;
      shd_s2 <= shd_s1;
    end
  end

  // ************************************************************
  // Register file and bus slave
  // ************************************************************
  ctrl_t ctrl_reg;
  trig_cfg_t trig_cfg_reg;
  irq_t irq_stat_reg, irq_mask_reg, irq_set;
  logic aw_held, w_held;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire, cmd_en, cmd_dis, cmd_setup, cmd_clear, cmd_fire;
  logic [31:0] wr_word, status_word, rd_word;
  out_state_t state_reg, state_next;
  logic shutdown_reg, armed_reg, trig_mode_reg, trig_level_reg;
  logic [15:0] trig_width_reg, pulse_cnt_reg;

  assign wr_fire = aw_held && w_held && !BVALID;
  assign wr_word = merge(32'h0, w_data_reg, w_strb_reg);
  assign cmd_en = wr_fire && aw_addr_reg == `OFS_CMD && wr_word[`CMD_OUT_ENABLE];
  assign cmd_dis = wr_fire && aw_addr_reg == `OFS_CMD && wr_word[`CMD_OUT_DISABLE];
  assign cmd_setup = wr_fire && aw_addr_reg == `OFS_CMD && wr_word[`CMD_LIST_TRIG_SETUP];
  assign cmd_clear = wr_fire && aw_addr_reg == `OFS_CMD && wr_word[`CMD_LIST_CLEAR];
  assign cmd_fire = wr_fire && aw_addr_reg == `OFS_CMD && wr_word[`CMD_FIRE_TRIG_OUT];

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= `AXI_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        AWREADY <= 1'b0;
        aw_addr_reg <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        WREADY <= 1'b0;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
      end
      if (wr_fire) begin
        BVALID <= 1'b1;
        BRESP <= mapped(aw_addr_reg) ? `AXI_OKAY : `AXI_SLVERR;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ctrl_reg <= `CTRL_RESET;
      trig_cfg_reg <= `TRIG_CFG_RESET;
      irq_mask_reg <= `IRQ_RESET;
    end else if (CE && wr_fire) begin
      case (aw_addr_reg)
        `OFS_CTRL: ctrl_reg <= w_strb_reg[0] ? ctrl_t'(w_data_reg[2:0]) : ctrl_reg;
        `OFS_TRIG_CFG: trig_cfg_reg <= {wr_word[31:`TRIG_WIDTH_LSB], wr_word[0]};
        `OFS_IRQ_MASK: irq_mask_reg <= w_strb_reg[0] ? irq_t'(w_data_reg[3:0]) : irq_mask_reg;
        default: ;
      endcase
    end
  end

  assign status_word = {26'h0, sw_s2, trig_mode_reg, armed_reg, shutdown_reg,
                        state_reg == OUT_STBY, state_reg == OUT_ON};

  always_comb begin
    case (ARADDR)
      `OFS_CTRL: rd_word = {29'h0, ctrl_reg};
      `OFS_TRIG_CFG: rd_word = {trig_cfg_reg.width, 15'h0, trig_cfg_reg.active_level};
      `OFS_STATUS: rd_word = status_word;
      `OFS_IRQ_STAT: rd_word = {28'h0, irq_stat_reg};
      `OFS_IRQ_MASK: rd_word = {28'h0, irq_mask_reg};
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= `AXI_OKAY;
    end else if (CE) begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= rd_word;
        RRESP <= mapped(ARADDR) ? `AXI_OKAY : `AXI_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Qualifiers
  // ************************************************************
  logic sw_off_q, trig_q, trig_event;

  pulse_qualifier u_switch_qual (
    .clk(CORE_CLK),
    .ce(CE),
    .rst_n(RST_N),
    .active(!(sw_s2 ^ ctrl_reg.invert_switch)),
    .qualified(sw_off_q)
  );

  pulse_qualifier u_trigger_qual (
    .clk(CORE_CLK),
    .ce(CE),
    .rst_n(RST_N),
    .active(!trg_s2),
    .qualified(trig_q)
  );

  // ************************************************************
  // Trigger arming
  // ************************************************************
  assign trig_event = armed_reg && trig_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      armed_reg <= 1'b1;
    end else if (CE) begin
      if (trig_event) armed_reg <= 1'b0;
      else if (trg_s2) armed_reg <= 1'b1;
    end
  end

  // ************************************************************
  // Shutdown latch
  // ************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) shutdown_reg <= 1'b0;
    else if (CE) shutdown_reg <= shutdown_reg | shd_s2;
  end

  // ************************************************************
  // Output state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    if (shutdown_reg) begin
      state_next = OUT_SHDN;
    end else begin
      case (state_reg)
        OUT_SHDN: state_next = OUT_SHDN;
        OUT_ON: begin
          if (ctrl_reg.ignore_switch) begin
            if (cmd_dis) state_next = OUT_OFF;
          end else if (ctrl_reg.standby_mode) begin
            if (sw_off_q) state_next = OUT_STBY;
            else if (cmd_dis) state_next = OUT_OFF;
          end else if (sw_off_q) begin
            state_next = OUT_OFF;
          end
        end
        OUT_OFF, OUT_STBY: begin
          if (ctrl_reg.ignore_switch || ctrl_reg.standby_mode) begin
            if (cmd_en) state_next = OUT_ON;
          end else if (!sw_off_q) begin
            state_next = OUT_ON;
          end
        end
        default: state_next = OUT_OFF;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) state_reg <= OUT_OFF;
    else if (CE) state_reg <= state_next;
  end

  // ************************************************************
  // Trigger output use of the output-off flag
  // ************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      trig_mode_reg <= 1'b0;
      trig_level_reg <= 1'b1;
      trig_width_reg <= 16'h0001;
    end else if (CE) begin
      if (cmd_setup) begin
        trig_mode_reg <= 1'b1;
        trig_level_reg <= trig_cfg_reg.active_level;
        trig_width_reg <= (trig_cfg_reg.width == 16'h0) ? 16'h0001 : trig_cfg_reg.width;
      end else if (cmd_clear) begin
        trig_mode_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) pulse_cnt_reg <= 16'h0;
    else if (CE) begin
      if (trig_mode_reg && (trig_event || cmd_fire)) pulse_cnt_reg <= trig_width_reg;
      else if (pulse_cnt_reg != 16'h0) pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  assign irq_set = '{switch_off: sw_off_q && state_reg == OUT_ON && state_next != OUT_ON,
                     standby: state_reg != OUT_STBY && state_next == OUT_STBY,
                     shutdown: shd_s2 && !shutdown_reg,
                     trigger: trig_event};

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      irq_stat_reg <= `IRQ_RESET;
      IRQ <= 1'b0;
    end else if (CE) begin
      if (wr_fire && aw_addr_reg == `OFS_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~irq_t'(wr_word[3:0])) | irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ************************************************************
  // Output flops
  // ************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      OUTPUT_ENABLE <= 1'b0;
      POWER_FAULT_RED <= 1'b0;
      POWER_OK_FLAG_ON <= 1'b0;
      OUTPUT_OFF_FLAG_ON <= 1'b1;
      TRIGGER_EVENT <= 1'b0;
    end else if (CE) begin
      OUTPUT_ENABLE <= state_reg == OUT_ON && !shutdown_reg;
      POWER_FAULT_RED <= shutdown_reg;
      POWER_OK_FLAG_ON <= !shutdown_reg;
      if (trig_mode_reg)
        OUTPUT_OFF_FLAG_ON <= (pulse_cnt_reg != 16'h0) ? trig_level_reg : !trig_level_reg;
      else
        OUTPUT_OFF_FLAG_ON <= !(state_reg == OUT_ON && !shutdown_reg);
      TRIGGER_EVENT <= trig_event;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_shutdown_latch: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    shutdown_reg |=> shutdown_reg) else $error("shutdown latch released");

  a_shutdown_fast: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    shd_s2 |-> ##[1:2] (!OUTPUT_ENABLE && POWER_FAULT_RED)) else $error("shutdown too slow");

  a_fault_red: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    shutdown_reg |=> (POWER_FAULT_RED && !OUTPUT_ENABLE && state_reg == OUT_SHDN))
    else $error("shutdown without fault state");

  a_power_ok: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    1'b1 |=> POWER_OK_FLAG_ON == !$past(shutdown_reg)) else $error("power ok flag wrong");

  a_trig_rearm: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    trig_event ##1 !trg_s2 |-> !armed_reg && !trig_event) else $error("trigger rearmed early");

  a_trig_event: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    $rose(trig_q) && armed_reg |=> TRIGGER_EVENT ##1 !TRIGGER_EVENT)
    else $error("trigger event not single");

  a_standby_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    state_reg == OUT_STBY && !cmd_en |=> state_reg != OUT_ON) else $error("left standby");

  a_standby_enter: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    state_reg == OUT_ON && ctrl_reg.standby_mode && !ctrl_reg.ignore_switch && sw_off_q
    && !shutdown_reg |=> state_reg == OUT_STBY ##1 !OUTPUT_ENABLE) else $error("no standby");

  a_flag_default: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    !trig_mode_reg |=> OUTPUT_OFF_FLAG_ON == !OUTPUT_ENABLE) else $error("off flag wrong");

  a_pulse_level: assert property (@(posedge CORE_CLK) disable iff (!RST_N || !CE)
    trig_mode_reg && pulse_cnt_reg != 16'h0 |=> OUTPUT_OFF_FLAG_ON == $past(trig_level_reg))
    else $error("trigger pulse level wrong");

endmodule // output_control_trigger_inputs

`default_nettype wire

// *** verilog/pulse_qualifier.sv ***
/*
  Low-level qualifier: flags a level held active for a minimum number of cycles.
  Assumes its input is already synchronised to clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "octl_map.svh"

module pulse_qualifier (
  input wire logic clk,
  input wire logic ce,
  input wire logic rst_n,
  input wire logic active,
  output logic qualified
);

  logic [`QCNT_W-1:0] cnt_reg;

  // ************************************************************
  // Duration counter
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      qualified <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        cnt_reg <= '0;
        qualified <= 1'b0;
      end else if (cnt_reg != `QCNT_W'(`QUAL_CYCLES)) begin
        cnt_reg <= cnt_reg + `QCNT_W'(1);
      end else begin
        qualified <= 1'b1;
      end
    end
  end

endmodule // pulse_qualifier

`default_nettype wire
